// ---- design/thresh_pkg.sv ----
// Purpose: shared constants for the temperature warning and input
//          overvoltage threshold commands
// Assumes: linear words, fixed point with 8 fraction bits
// Notes:   offsets, fields, reset values and counts
package thresh_pkg;

    // ************************************************************
    // command codes
    // ************************************************************
    localparam logic [7:0] CODE_TEMP_WARN = 8'h51; // warning threshold
    localparam logic [7:0] CODE_INPUT_OVERVOLTAGE_FLAG = 8'h55; // input ov threshold
    localparam logic [7:0] CODE_VIN_ACT = 8'h56; // input ov action byte

    // ************************************************************
    // linear word fields
    // ************************************************************
    localparam int EXP_MSB = 15; // exponent top bit
    localparam int EXP_LSB = 11; // exponent low bit
    localparam int MAN_MSB = 10; // mantissa top bit
    localparam int ACT_RESP_MSB = 7; // action response field top
    localparam int ACT_RESP_LSB = 6; // action response field low
    localparam logic [1:0] ACT_RESP_BAD = 2'h3; // unsupported response

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [4:0] TEMP_EXP_RST = 5'h00; // whole degrees
    localparam logic [4:0] VIN_EXP_RST = 5'h1E; // quarter volts
    localparam logic [10:0] TEMP_MAN_RST = 11'h07D; // default degrees
    localparam logic [10:0] VIN_MAN_RST = 11'h03C; // default quarters
    localparam logic [7:0] VIN_ACT_RST = 8'h80; // default action

    // ************************************************************
    // fixed point limits (8 fraction bits)
    // ************************************************************
    localparam int FRAC = 8; // fraction bits of compared values
    localparam int FIX_W = 40; // width of compared values
    localparam int TELE_W = 24; // width of telemetry samples
    localparam logic signed [39:0] TEMP_MIN_FIX = 40'sh0;
    localparam logic signed [39:0] TEMP_MAX_FIX = 40'shA000; // 160 C
    localparam logic signed [39:0] TEMP_OFF_FIX = 40'shFF00; // 255 C
    localparam logic signed [39:0] TEMP_HYST_FIX = 40'sh1400; // 20 C
    localparam logic signed [39:0] VIN_MIN_FIX = 40'sh500; // 5 V
    localparam logic signed [39:0] VIN_MAX_FIX = 40'sh1600; // 22 V
    localparam int VIN_GRID_BITS = 6; // fraction bits below 0.25 V
    localparam logic signed [39:0] HALF_DEG_FIX = 40'sh80; // round deg
    localparam logic signed [39:0] HALF_QTR_FIX = 40'sh20; // round qtr
    localparam logic signed [39:0] TEMP_NVM_MAX = 40'shA0; // 160 deg
    localparam logic signed [39:0] VIN_QTR_MIN = 40'sh14; // 20 qtr
    localparam logic signed [39:0] VIN_QTR_MAX = 40'sh58; // 88 qtr

    // ************************************************************
    // status flag positions
    // ************************************************************
    localparam int FLG_TEMP_SUM = 0; // temperature summary
    localparam int FLG_TEMP_WARN = 1; // temperature warning
    localparam int FLG_INVALID = 2; // invalid data written
    localparam int FLG_OTHER = 3; // other fault summary
    localparam int FLG_INPUT = 4; // input summary, upper word
    localparam int FLG_INPUT_OVERVOLTAGE_FLAG = 5; // input overvoltage
    localparam int FLAG_N = 6; // number of sticky flags

    // join an exponent and a mantissa into one linear word
    function automatic logic [15:0] lin_word(input logic [4:0] e,
                                             input logic [10:0] m);
        lin_word = {e, m};
    endfunction : lin_word

endpackage : thresh_pkg

// ---- design/lin_to_fixed.sv ----
// Purpose: turn a linear format word into a signed fixed point value
// Assumes: exponent and mantissa are both two's complement
// Notes:   exponents below -8 drop low bits
`timescale 1ns/1ns
module lin_to_fixed
    import thresh_pkg::*;
(
    input wire logic [15:0] word,
    output logic signed [FIX_W-1:0] value
);

    // ************************************************************
    // shift the mantissa by the exponent
    // ************************************************************
    always_comb begin
        logic signed [4:0] e;
        logic signed [FIX_W-1:0] m;
        int sh;
        e = signed'(word[EXP_MSB:EXP_LSB]);
        m = FIX_W'(signed'(word[MAN_MSB:0]));
        sh = int'(e) + FRAC;
        // left shift grows, right shift truncates
        if (sh >= 0) begin
            value = m <<< sh;
        end else begin
            value = m >>> (-sh);
        end
    end

endmodule : lin_to_fixed

// ---- design/sticky_flags.sv ----
// Purpose: bank of sticky status flags
// Assumes: set and clear are one-cycle requests
// Notes:   a set beats a clear in one cycle
`timescale 1ns/1ns
module sticky_flags #(
    parameter int N = 6
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [N-1:0] set,
    input wire logic clr,
    output logic [N-1:0] q
);

    // ************************************************************
    // one flop per flag
    // ************************************************************
    for (genvar i = 0; i < N; i++) begin : g_flag
        // hold, set, or clear when not set
        always_ff @(posedge mclk) begin
            if (rst) begin
                q[i] <= 1'b0;
            end else if (ce) begin
                if (set[i]) begin
                    q[i] <= 1'b1;
                end else if (clr) begin
                    q[i] <= 1'b0;
                end
            end
        end
    end

endmodule : sticky_flags

// ---- design/temp_warn_input_ov_limits.sv ----
// Purpose: warning and input overvoltage threshold commands
//          with range checks, flags and store/restore
// Assumes: commands arrive decoded from the bus;
//          samples are signed, 8 fraction bits
// Notes:   rst models a power cycle
//
// Functional notes
// - warning threshold command at code 51h
// - warning word: exponent 15:11, mantissa 10:0
// - crossing sets temp summary, notifies host
// - crossing sets temperature warning flag
// - unsupported warning write rejected, flagged, notified
// - live warning threshold keeps full resolution
// - stored warning threshold: 0 to 160 degrees
// - restore loads nearest storable warning value
// - 255 degrees disables the warning
// - warning threshold is the fault release point
// - else release 20 degrees below fault threshold
// - fault released, restart allowed below release
// - input overvoltage threshold at code 55h
// - input threshold word, exponent resets 11110b
// - input threshold accepts 5 to 22 V, quarters
// - out of range input write flagged, notified
// - restore loads nearest input threshold step
// - fault action comes from the action byte
// - action byte is one byte at 56h
// - input fault sets three flags, notifies host
`timescale 1ns/1ns
module temp_warn_input_ov_limits
    import thresh_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_word,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] rd_data,
    output logic rd_valid,
    input wire logic clear_faults,
    input wire logic store_req,
    input wire logic restore_req,
    input wire logic temp_valid,
    input wire logic signed [TELE_W-1:0] temp_sample,
    input wire logic vin_valid,
    input wire logic signed [TELE_W-1:0] vin_sample,
    input wire logic [15:0] temp_fault_threshold,
    output logic temp_summary_flag,
    output logic temp_warning_flag,
    output logic invalid_data_flag,
    output logic other_fault_summary_flag,
    output logic input_summary_flag,
    output logic input_overvoltage_flag,
    output logic alert_n,
    output logic input_overvoltage_flag_fault,
    output logic [7:0] input_overvoltage_action,
    output logic ot_fault,
    output logic ot_restart_ok
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [15:0] warn_q; // live warning threshold word
    logic [15:0] vin_thr_q; // live input threshold word
    logic [7:0] act_q; // live action byte
    logic [10:0] nvm_warn_q; // stored warning, whole degrees
    logic [10:0] nvm_vin_q; // stored input threshold, quarters
    logic [7:0] nvm_act_q; // stored action byte
    logic [FLAG_N-1:0] flags; // sticky status flags
    logic [FLAG_N-1:0] flag_set; // flag set requests
    logic [15:0] rd_data_q; // read answer
    logic rd_valid_q; // read answer strobe
    logic alert_n_q; // host notification, low active
    logic vin_fault_q; // input overvoltage level
    logic ot_fault_q; // over-temperature fault held
    logic ot_restart_q; // release pulse

    // ************************************************************
    // fixed point views of the thresholds and samples
    // ************************************************************
    logic signed [FIX_W-1:0] warn_fix; // warning threshold
    logic signed [FIX_W-1:0] vin_fix; // input threshold
    logic signed [FIX_W-1:0] fault_fix; // fault threshold
    logic signed [FIX_W-1:0] wr_fix; // value being written
    logic signed [FIX_W-1:0] temp_fix; // temperature sample
    logic signed [FIX_W-1:0] vsam_fix; // input rail sample

    // live warning word, full resolution
    lin_to_fixed u_warn (
        .word(warn_q),
        .value(warn_fix)
    );

    // live input threshold word
    lin_to_fixed u_vin (
        .word(vin_thr_q),
        .value(vin_fix)
    );

    // fault threshold word
    lin_to_fixed u_fault (
        .word(temp_fault_threshold),
        .value(fault_fix)
    );

    // write data, for range checks
    lin_to_fixed u_wr (
        .word(cmd_wdata),
        .value(wr_fix)
    );

    assign temp_fix = FIX_W'(temp_sample);
    assign vsam_fix = FIX_W'(vin_sample);

    // ************************************************************
    // write decode and range checks
    // ************************************************************
    logic wr_en; // a write command this cycle
    logic wr_warn; // accepted warning write
    logic wr_vin; // accepted input threshold write
    logic wr_act; // accepted action write
    logic wr_bad; // rejected write
    logic warn_ok; // warning value supported
    logic vin_ok; // input value supported
    logic act_ok; // action byte supported

    // decide which writes are taken or refused
    always_comb begin
        wr_en = ce && cmd_valid && cmd_write;
        // 0..160 degrees at full resolution, or off
        warn_ok = ((wr_fix >= TEMP_MIN_FIX) && (wr_fix <= TEMP_MAX_FIX))
                  || (wr_fix == TEMP_OFF_FIX);
        // 5..22 volts on the quarter volt grid
        vin_ok = (wr_fix >= VIN_MIN_FIX) && (wr_fix <= VIN_MAX_FIX)
                 && (wr_fix[VIN_GRID_BITS-1:0] == '0);
        // response code 11b is not supported
        act_ok = cmd_wdata[ACT_RESP_MSB:ACT_RESP_LSB] != ACT_RESP_BAD;
        wr_warn = 1'b0;
        wr_vin = 1'b0;
        wr_act = 1'b0;
        wr_bad = 1'b0;
        if (wr_en) begin
            case (cmd_code)
                // warning threshold, word sized
                CODE_TEMP_WARN: begin
                    wr_warn = cmd_word && warn_ok;
                    wr_bad = !(cmd_word && warn_ok);
                end
                // input threshold, word sized
                CODE_INPUT_OVERVOLTAGE_FLAG: begin
                    wr_vin = cmd_word && vin_ok;
                    wr_bad = !(cmd_word && vin_ok);
                end
                // action byte, byte sized
                CODE_VIN_ACT: begin
                    wr_act = !cmd_word && act_ok;
                    wr_bad = !(!cmd_word && act_ok);
                end
                // other codes belong to other blocks
                default: begin
                    wr_bad = 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // rounding onto the storable grids
    // ************************************************************
    logic signed [FIX_W-1:0] warn_deg; // warning, nearest degree
    logic signed [FIX_W-1:0] vin_qtr; // input, nearest quarter volt
    logic [10:0] warn_store; // clamped degrees
    logic [10:0] vin_store; // clamped quarters

    // round to nearest step, clamp to stored range
    always_comb begin
        warn_deg = (warn_fix + HALF_DEG_FIX) >>> FRAC;
        vin_qtr = (vin_fix + HALF_QTR_FIX) >>> VIN_GRID_BITS;
        if (warn_deg < TEMP_MIN_FIX) begin
            warn_store = '0;
        end else if (warn_deg > TEMP_NVM_MAX) begin
            warn_store = TEMP_NVM_MAX[10:0];
        end else begin
            warn_store = warn_deg[10:0];
        end
        if (vin_qtr < VIN_QTR_MIN) begin
            vin_store = VIN_QTR_MIN[10:0];
        end else if (vin_qtr > VIN_QTR_MAX) begin
            vin_store = VIN_QTR_MAX[10:0];
        end else begin
            vin_store = vin_qtr[10:0];
        end
    end

    // ************************************************************
    // stored copies, taken on a store request
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            nvm_warn_q <= TEMP_MAN_RST;
            nvm_vin_q <= VIN_MAN_RST;
            nvm_act_q <= VIN_ACT_RST;
        end else if (ce && store_req) begin
            nvm_warn_q <= warn_store;
            nvm_vin_q <= vin_store;
            nvm_act_q <= act_q;
        end
    end

    // ************************************************************
    // live command values
    // ************************************************************
    // rst loads the reset defaults, restore loads stored values;
    // restore beats a same-cycle write
    always_ff @(posedge mclk) begin
        if (rst) begin
            warn_q <= lin_word(TEMP_EXP_RST, TEMP_MAN_RST);
            vin_thr_q <= lin_word(VIN_EXP_RST, VIN_MAN_RST);
            act_q <= VIN_ACT_RST;
        end else if (ce) begin
            if (restore_req) begin
                warn_q <= lin_word(TEMP_EXP_RST, nvm_warn_q);
                vin_thr_q <= lin_word(VIN_EXP_RST, nvm_vin_q);
                act_q <= nvm_act_q;
            end else begin
                // accepted writes keep every bit
                if (wr_warn) begin
                    warn_q <= cmd_wdata;
                end
                if (wr_vin) begin
                    vin_thr_q <= cmd_wdata;
                end
                if (wr_act) begin
                    act_q <= cmd_wdata[7:0];
                end
            end
        end
    end

    // ************************************************************
    // read answers
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_data_q <= '0;
            rd_valid_q <= 1'b0;
        end else if (ce) begin
            rd_valid_q <= cmd_valid && !cmd_write;
            if (cmd_valid && !cmd_write) begin
                case (cmd_code)
                    // warning threshold word
                    CODE_TEMP_WARN: begin
                        rd_data_q <= warn_q;
                    end
                    // input threshold word
                    CODE_INPUT_OVERVOLTAGE_FLAG: begin
                        rd_data_q <= vin_thr_q;
                    end
                    // action byte in the low lane
                    CODE_VIN_ACT: begin
                        rd_data_q <= {8'h00, act_q};
                    end
                    // unknown codes read as zero
                    default: begin
                        rd_data_q <= '0;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // threshold comparisons
    // ************************************************************
    logic warn_off; // warning disabled by 255 degrees
    logic warn_hit; // sample above the warning threshold
    logic vin_hit; // sample above the input threshold
    logic ot_hit; // sample above the fault threshold
    logic ot_clear; // sample below the release point
    logic signed [FIX_W-1:0] release_fix; // fault release point

    // compare each sample with the live thresholds
    always_comb begin
        warn_off = warn_fix == TEMP_OFF_FIX;
        warn_hit = temp_valid && !warn_off
                   && (temp_fix > warn_fix);
        vin_hit = vin_valid && (vsam_fix > vin_fix);
        ot_hit = temp_valid && (temp_fix > fault_fix);
        // warning is the release point unless off or above fault
        if (warn_off || (warn_fix > fault_fix)) begin
            release_fix = fault_fix - TEMP_HYST_FIX;
        end else begin
            release_fix = warn_fix;
        end
        ot_clear = temp_valid && (temp_fix < release_fix);
    end

    // ************************************************************
    // status flags and host notification
    // ************************************************************
    // events to their flag positions
    always_comb begin
        flag_set = '0;
        flag_set[FLG_TEMP_SUM] = warn_hit;
        flag_set[FLG_TEMP_WARN] = warn_hit;
        flag_set[FLG_INVALID] = wr_bad;
        flag_set[FLG_OTHER] = vin_hit;
        flag_set[FLG_INPUT] = vin_hit;
        flag_set[FLG_INPUT_OVERVOLTAGE_FLAG] = vin_hit;
    end

    // sticky bank; a new event beats clear
    sticky_flags #(
        .N(FLAG_N)
    ) u_flags (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .set(flag_set),
        .clr(clear_faults),
        .q(flags)
    );

    // alert stays low while any flag stands
    always_ff @(posedge mclk) begin
        if (rst) begin
            alert_n_q <= 1'b1;
        end else if (ce) begin
            alert_n_q <= ~|flags;
        end
    end

    // ************************************************************
    // fault levels
    // ************************************************************
    // input fault level follows each rail sample
    always_ff @(posedge mclk) begin
        if (rst) begin
            vin_fault_q <= 1'b0;
        end else if (ce && vin_valid) begin
            vin_fault_q <= vin_hit;
        end
    end

    // fault held until below the release point
    always_ff @(posedge mclk) begin
        if (rst) begin
            ot_fault_q <= 1'b0;
            ot_restart_q <= 1'b0;
        end else if (ce) begin
            ot_restart_q <= 1'b0;
            if (ot_hit) begin
                ot_fault_q <= 1'b1;
            end else if (ot_fault_q && ot_clear) begin
                ot_fault_q <= 1'b0;
                ot_restart_q <= 1'b1;
            end
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign temp_summary_flag = flags[FLG_TEMP_SUM];
    assign temp_warning_flag = flags[FLG_TEMP_WARN];
    assign invalid_data_flag = flags[FLG_INVALID];
    assign other_fault_summary_flag = flags[FLG_OTHER];
    assign input_summary_flag = flags[FLG_INPUT];
    assign input_overvoltage_flag = flags[FLG_INPUT_OVERVOLTAGE_FLAG];
    assign alert_n = alert_n_q;
    assign input_overvoltage_flag_fault = vin_fault_q;
    assign input_overvoltage_action = act_q;
    assign ot_fault = ot_fault_q;
    assign ot_restart_ok = ot_restart_q;

endmodule : temp_warn_input_ov_limits

// ---- dv/thresh_sva.sv ----
// Purpose: port assertions for the threshold block
// Assumes: ce is held high by the bench
// Notes: attached by bind from the bench top
`timescale 1ns/1ns
module thresh_sva
    import thresh_pkg::*;
(
    input wire logic mclk, rst, cmd_valid, cmd_write, cmd_word,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic rd_valid, restore_req, temp_valid, vin_valid,
    input wire logic temp_summary_flag, temp_warning_flag,
    input wire logic invalid_data_flag, other_fault_summary_flag,
    input wire logic input_summary_flag, input_overvoltage_flag,
    input wire logic alert_n, input_overvoltage_flag_fault, ot_fault, ot_restart_ok,
    input wire logic [7:0] input_overvoltage_action
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    logic any_flag; // any sticky flag up
    assign any_flag = temp_summary_flag | temp_warning_flag |
        invalid_data_flag | other_fault_summary_flag |
        input_summary_flag | input_overvoltage_flag;
    a_read_answer: assert property (cmd_valid && !cmd_write |=> rd_valid)
        else $error("read got no answer strobe");
    a_read_cause: assert property (rd_valid |-> $past(cmd_valid) &&
        !$past(cmd_write)) else $error("answer strobe without a read");
    a_warn_cause: assert property ($rose(temp_warning_flag) |->
        $past(temp_valid)) else $error("warning flag without a sample");
    a_warn_summary: assert property (temp_warning_flag |->
        temp_summary_flag) else $error("warning without summary flag");
    a_alert_follows: assert property (alert_n != $past(any_flag))
        else $error("alert_n does not follow the flags");
    a_input_flags: assert property (input_overvoltage_flag |->
        other_fault_summary_flag && input_summary_flag)
        else $error("input fault flags incomplete");
    a_vin_cause: assert property ($rose(input_overvoltage_flag_fault) |->
        $past(vin_valid)) else $error("input fault without a sample");
    a_action_write: assert property (cmd_valid && cmd_write &&
        !cmd_word && cmd_code == CODE_VIN_ACT && !restore_req &&
        cmd_wdata[7:6] != ACT_RESP_BAD |=> input_overvoltage_action
        == 8'($past(cmd_wdata))) else $error("action byte not stored");
    a_size_refused: assert property (cmd_valid && cmd_write &&
        !cmd_word && cmd_code == CODE_INPUT_OVERVOLTAGE_FLAG |=> invalid_data_flag)
        else $error("byte write of threshold not flagged");
    a_restart_free: assert property (ot_restart_ok |-> !ot_fault)
        else $error("restart while fault held");
endmodule : thresh_sva

// ---- dv/host_model.sv ----
// Purpose: host side command driver
// Assumes: one command at a time
// Notes: idle data shows the inverse of the last word
`timescale 1ns/1ns
module host_model (
    input wire logic mclk,
    output logic cmd_valid,
    output logic cmd_write,
    output logic cmd_word,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata
);
    initial {cmd_valid, cmd_write, cmd_word, cmd_code, cmd_wdata} = '0;
    // raise after an edge, drop after the taking edge
    task automatic send(input logic w, wd, input logic [7:0] c,
                        input logic [15:0] d);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_word <= wd;
        cmd_code <= c;
        cmd_wdata <= d;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd_wdata <= ~d;
    endtask : send
endmodule : host_model

// ---- dv/temp_warn_input_ov_limits_tb_top.sv ----
// Purpose: self-checking bench for the threshold block
// Assumes: ce held high, commands through host_model
// Notes: read answers are scored from a queue of expected words
`timescale 1ns/1ns
module temp_warn_input_ov_limits_tb_top import thresh_pkg::*;;
    logic mclk = 0, rst = 1, temp_valid = 0, vin_valid = 0;
    logic [2:0] req = '0; // clear, store, restore
    logic cmd_valid, cmd_write, cmd_word, rd_valid, temp_summary_flag;
    logic temp_warning_flag, invalid_data_flag, other_fault_summary_flag;
    logic input_summary_flag, input_overvoltage_flag, alert_n;
    logic input_overvoltage_flag_fault, ot_fault, ot_restart_ok;
    logic [7:0] cmd_code, input_overvoltage_action, q;
    logic [15:0] cmd_wdata, rd_data, fault_word = 16'h0064, exp_q[$];
    logic [15:0] bad[4] = '{16'hF058, 16'hF059, 16'hF013, 16'hE829};
    logic signed [TELE_W-1:0] temp_sample = '0, vin_sample = '0;
    int n_errors = 0, n_compared = 0;
    always #5 mclk = ~mclk;
    host_model u_host (.*);
    temp_warn_input_ov_limits u_dut (.*, .ce(1'b1),
        .clear_faults(req[0]), .store_req(req[1]),
        .restore_req(req[2]), .temp_fault_threshold(fault_word));
    task automatic check(input string nm, input logic [15:0] s, e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic wr(input logic [7:0] c, input logic [15:0] d,
                      input logic wd = 1);
        u_host.send(1'b1, wd, c, d);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] c, input logic [15:0] e,
                      input logic wd = 1);
        exp_q.push_back(e);
        u_host.send(1'b0, wd, c, 16'h0000);
    endtask : rd
    task automatic pulse(input int k);
        @(posedge mclk) req[k] <= 1'b1;
        @(posedge mclk) req[k] <= 1'b0;
        #1;
    endtask : pulse
    // one telemetry sample, v selects the input rail
    task automatic tele(input logic v, input logic signed [23:0] s);
        @(posedge mclk);
        {temp_valid, vin_valid, temp_sample, vin_sample} <= {!v, v, s, s};
        @(posedge mclk);
        {temp_valid, vin_valid, temp_sample, vin_sample} <= {2'b0, ~s, ~s};
        #1;
    endtask : tele
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // score each read answer against the oldest note
    always @(posedge mclk) begin
        if (rd_valid === 1) check("rd", rd_data, exp_q.pop_front());
    end
    initial begin
        #100000 n_errors++;
        conclude();
    end
    initial begin
        void'($urandom(32'h10DC6B74));
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rd(CODE_TEMP_WARN, 16'h007D);
        rd(CODE_INPUT_OVERVOLTAGE_FLAG, 16'hF03C);
        rd(CODE_VIN_ACT, 16'h0080, 1'b0);
        wr(CODE_VIN_ACT, 16'h0045, 1'b0);
        wr(CODE_TEMP_WARN, 16'hF8A1);
        rd(CODE_TEMP_WARN, 16'hF8A1);
        tele(0, 24'sh005080);
        check("warn equal", temp_warning_flag, 1'b0);
        tele(0, 24'sh005081);
        check("warn", temp_warning_flag, 1'b1);
        check("summary", temp_summary_flag, 1'b1);
        @(posedge mclk) #1 check("alert", alert_n, 1'b0);
        pulse(0);
        wr(CODE_TEMP_WARN, 16'h00A1);
        check("bad warn", invalid_data_flag, 1'b1);
        rd(CODE_TEMP_WARN, 16'hF8A1);
        foreach (bad[i]) begin
            pulse(0);
            wr(CODE_INPUT_OVERVOLTAGE_FLAG, bad[i], i != 0);
            check("bad vin", invalid_data_flag, 1'b1);
        end
        repeat (4) begin
            q = 8'(20 + $urandom % 69);
            wr(CODE_INPUT_OVERVOLTAGE_FLAG, {5'h1E, 3'h0, q});
            rd(CODE_INPUT_OVERVOLTAGE_FLAG, {5'h1E, 3'h0, q});
        end
        rd(CODE_VIN_ACT, 16'h0045, 1'b0);
        $display("test registers done");
        wr(CODE_INPUT_OVERVOLTAGE_FLAG, 16'hF014);
        pulse(0);
        tele(1, 24'sh000500);
        check("vin equal", input_overvoltage_flag_fault, 1'b0);
        tele(1, 24'sh000501);
        check("vin fault", input_overvoltage_flag_fault, 1'b1);
        check("vin flag", input_overvoltage_flag, 1'b1);
        check("other", other_fault_summary_flag, 1'b1);
        check("input", input_summary_flag, 1'b1);
        $display("test input fault done");
        wr(CODE_TEMP_WARN, 16'h005A);
        tele(0, 24'sh006500);
        check("ot set", ot_fault, 1'b1);
        tele(0, 24'sh005B00);
        check("ot hold", ot_fault, 1'b1);
        tele(0, 24'sh005900);
        check("ot free", ot_fault, 1'b0);
        check("restart", ot_restart_ok, 1'b1);
        wr(CODE_TEMP_WARN, 16'h00FF);
        pulse(0);
        tele(0, 24'sh006500);
        check("warn off", temp_warning_flag, 1'b0);
        tele(0, 24'sh005500);
        check("ot hyst", ot_fault, 1'b1);
        tele(0, 24'sh004F00);
        check("ot hyst free", ot_fault, 1'b0);
        $display("test fault release done");
        wr(CODE_TEMP_WARN, 16'hF143);
        wr(CODE_INPUT_OVERVOLTAGE_FLAG, 16'hF815);
        pulse(1);
        wr(CODE_TEMP_WARN, 16'h0030);
        pulse(2);
        rd(CODE_TEMP_WARN, 16'h0051);
        rd(CODE_INPUT_OVERVOLTAGE_FLAG, 16'hF02A);
        repeat (3) @(posedge mclk);
        $display("test store restore done");
        conclude();
    end
endmodule : temp_warn_input_ov_limits_tb_top
bind temp_warn_input_ov_limits thresh_sva u_sva (.*);
